// File: src/afd_pkg.sv
package afd_pkg;
	// Register map, byte addresses.
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_IMM = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_PC = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_RF_BASE = 8'h80;
	// Command word fields.
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DST_LSB = 8;
	localparam int CMD_SRC_LSB = 16;
	localparam int CMD_LONG_BIT = 24;
	// Flag positions.
	localparam int F_C = 0;
	localparam int F_Z = 1;
	localparam int F_N = 2;
	localparam int F_V = 3;
	localparam int F_S = 4;
	localparam int F_H = 5;
	localparam int F_I = 7;
	// Values after reset.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] IMM_RST = 16'h0000;
	localparam logic [7:0] REG_RST = 8'h00;
	// Fixed register indices.
	localparam logic [4:0] REG_PROD_LO = 5'h00;
	localparam logic [4:0] REG_PROD_HI = 5'h01;
	localparam logic [4:0] REG_Z_LO = 5'h1E;
	localparam logic [4:0] REG_Z_HI = 5'h1F;
	// Program counter steps.
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
	localparam logic [15:0] PC_SKIP_LONG = 16'h0003;
	// Execution cycles.
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_PROD = 3'h2;
	localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
	localparam logic [2:0] CYC_SKIP_LONG = 3'h3;
	localparam logic [2:0] CYC_JUMP_REL = 3'h2;
	localparam logic [2:0] CYC_JUMP_ABS = 3'h3;
	localparam logic [2:0] CYC_CALL = 3'h3;
	localparam logic [2:0] CYC_EXIT = 3'h4;

	typedef enum logic [5:0] {
		OP_ADD = 6'b000000, OP_ADD_CARRY = 6'b000001, OP_WORD_SUM = 6'b000010,
		OP_DIFF = 6'b000011, OP_IMM_DIFF = 6'b000100, OP_DIFF_BORROW = 6'b000101,
		OP_IMM_DIFF_BORROW = 6'b000110, OP_WORD_DIFF = 6'b000111, OP_AND = 6'b001000,
		OP_IMM_MASK = 6'b001001, OP_OR = 6'b001010, OP_IMM_MERGE = 6'b001011,
		OP_XOR = 6'b001100, OP_INVERT = 6'b001101, OP_TWOS_INVERT = 6'b001110,
		OP_SET_BITS = 6'b001111, OP_CLEAR_BITS = 6'b010000, OP_INC = 6'b010001,
		OP_DEC = 6'b010010, OP_TEST = 6'b010011, OP_ZERO = 6'b010100,
		OP_FILL_ONES = 6'b010101, OP_UPROD = 6'b010110, OP_SPROD = 6'b010111,
		OP_MPROD = 6'b011000, OP_FUPROD = 6'b011001, OP_FSPROD = 6'b011010,
		OP_FMPROD = 6'b011011, OP_REL_JUMP = 6'b011100, OP_PTR_JUMP = 6'b011101,
		OP_ABS_JUMP = 6'b011110, OP_REL_CALL = 6'b011111, OP_SUB_EXIT = 6'b100000,
		OP_INT_EXIT = 6'b100001, OP_SKIP_EQ = 6'b100010, OP_CMP = 6'b100011,
		OP_CMP_BORROW = 6'b100100, OP_CMP_IMM = 6'b100101
	} afd_op_t;

	typedef enum logic [2:0] {
		ALU_ADD = 3'b000,
		ALU_SUB = 3'b001,
		ALU_AND = 3'b010,
		ALU_OR = 3'b011,
		ALU_XOR = 3'b100
	} afd_alu_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} afd_state_t;
endpackage : afd_pkg

// File: src/afd_alu8.sv
`timescale 1ns/1ps
module afd_alu8 (
	// Operation select
	input wire afd_pkg::afd_alu_t op,
	// Operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	// Result and flags
	output logic [7:0] res,
	output logic co,
	output logic ho,
	output logic vo
);
	import afd_pkg::*;
	logic [8:0] w;
	logic [4:0] lo;

	always_comb begin
		w = 9'h000;
		lo = 5'h00;
		case (op)
			ALU_ADD: begin
				lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
				w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			end
			ALU_SUB: begin
				lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
				w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			end
			ALU_AND: w = {1'b0, a & b};
			ALU_OR: w = {1'b0, a | b};
			ALU_XOR: w = {1'b0, a ^ b};
			default: w = 9'h000;
		endcase
		res = w[7:0];
		// On subtraction the ninth bit and the nibble carry are borrows.
		co = w[8];
		ho = lo[4];
		if (op == ALU_ADD) begin
			vo = (a[7] == b[7]) && (w[7] != a[7]);
		end else if (op == ALU_SUB) begin
			vo = (a[7] != b[7]) && (w[7] != a[7]);
		end else begin
			vo = 1'b0;
		end
	end
endmodule : afd_alu8

// File: src/afd_core.sv
`timescale 1ns/1ps
// Operation
// (RULE1) Register add, optionally with carry, in one cycle; Z C N V H.
// (RULE2) Word immediate add or subtract on a pair in two cycles; Z C N V S.
// (RULE3) Register subtract, optionally with borrow, in one cycle; Z C N V H.
// (RULE4) Immediate subtract from a register in one cycle; Z C N V H.
// (RULE5) Immediate subtract with borrow also subtracts carry; one cycle; Z C N V H.
// (RULE6) AND, OR, XOR with register or constant in one cycle; Z N V only. The core has no constant form of XOR, only OP_XOR with a register.
// (RULE7) Set bits ORs mask, clear bits ANDs inverted mask; one cycle; Z N V.
// (RULE8) Zero-or-minus check ANDs register with itself; one cycle; Z N V.
// (RULE9) Unsigned, signed, mixed products into registers 1:0 in two cycles; Z C.
// (RULE10) Fractional products are shifted left once; two cycles; Z C.
// (RULE11) Skip-if-equal advances past next instruction; 1, 2 or 3 cycles.
// (RULE12) Compares form the difference without storing it; one cycle; Z N V C H.
// (RULE13) Jumps 2 or 3 cycles, calls 3 and push, exits 4 and pop.
// (RULE14) Invert and negate set Z C N V (negate H too); inc/dec Z N V; fill none.
module afd_core #(
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Core state
	output logic EXEC_BUSY,
	output logic [15:0] PROG_COUNTER
);
	import afd_pkg::*;
	localparam int SPW = $clog2(STACK_DEPTH);

	logic [7:0] rf_q [32];
	logic [7:0] rf_d [32];
	logic [15:0] stk_q [STACK_DEPTH];
	logic [15:0] stk_d [STACK_DEPTH];
	logic [SPW-1:0] sp_q, sp_d;
	logic [7:0] flags_q, flags_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] imm_q, imm_d;
	afd_state_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [2:0] cyc_q, cyc_d;
	afd_op_t op_q, op_d;
	logic [4:0] dst_q, dst_d;
	logic [4:0] src_q, src_d;
	logic resp_q, resp_d;
	logic [31:0] rdata_q, rdata_d;

	logic acc, go, busy, cf;
	afd_op_t w_op;
	logic [4:0] w_dst, w_src, w_dhi;
	logic w_long;
	logic [7:0] ra, rb, k;

	// A request is taken on the edge where waitrequest is low.
	assign acc = (AVS_READ | AVS_WRITE) & resp_q;
	assign go = acc & AVS_WRITE & AVS_BYTEENABLE[0] & (AVS_ADDRESS == ADDR_CMD);
	assign w_op = afd_op_t'(AVS_WRITEDATA[CMD_OP_LSB +: 6]);
	assign w_dst = AVS_WRITEDATA[CMD_DST_LSB +: 5];
	assign w_src = AVS_WRITEDATA[CMD_SRC_LSB +: 5];
	assign w_long = AVS_WRITEDATA[CMD_LONG_BIT];
	assign w_dhi = w_dst + 5'h01;
	assign ra = rf_q[w_dst];
	assign rb = rf_q[w_src];
	assign k = imm_q[7:0];
	assign busy = (st_q == ST_EXEC);
	assign cf = flags_q[F_C];

	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~resp_q;
	assign AVS_READDATA = rdata_q;
	assign EXEC_BUSY = busy;
	assign PROG_COUNTER = pc_q;

	afd_alu_t alu_op;
	logic [7:0] alu_a, alu_b, alu_r;
	logic alu_cin, alu_c, alu_h, alu_v;

	always_comb begin
		alu_op = ALU_ADD;
		alu_a = ra;
		alu_b = rb;
		alu_cin = 1'b0;
		case (w_op)
			OP_ADD_CARRY: alu_cin = cf; // RULE1
			OP_DIFF, OP_CMP: alu_op = ALU_SUB; // RULE3
			OP_DIFF_BORROW, OP_CMP_BORROW: begin
				alu_op = ALU_SUB;
				alu_cin = cf; // RULE3
			end
			OP_IMM_DIFF, OP_CMP_IMM: begin
				alu_op = ALU_SUB;
				alu_b = k; // RULE4
			end
			OP_IMM_DIFF_BORROW: begin
				alu_op = ALU_SUB;
				alu_b = k;
				alu_cin = cf; // RULE5
			end
			OP_AND: alu_op = ALU_AND; // RULE6
			OP_IMM_MASK: begin
				alu_op = ALU_AND;
				alu_b = k; // RULE6
			end
			OP_OR: alu_op = ALU_OR; // RULE6
			OP_IMM_MERGE, OP_SET_BITS: begin
				alu_op = ALU_OR;
				alu_b = k; // RULE7
			end
			OP_CLEAR_BITS: begin
				alu_op = ALU_AND;
				alu_b = ~k; // RULE7
			end
			OP_XOR: alu_op = ALU_XOR; // RULE6
			OP_INVERT: begin
				alu_op = ALU_XOR;
				alu_b = 8'hFF; // RULE14
			end
			OP_TWOS_INVERT: begin
				alu_op = ALU_SUB;
				alu_a = 8'h00;
				alu_b = ra; // RULE14
			end
			OP_INC: alu_b = 8'h01; // RULE14
			OP_DEC: begin
				alu_op = ALU_SUB;
				alu_b = 8'h01; // RULE14
			end
			OP_TEST: begin
				alu_op = ALU_AND;
				alu_b = ra; // RULE8
			end
			OP_ZERO: begin
				alu_op = ALU_XOR;
				alu_b = ra;
			end
			default: alu_cin = 1'b0;
		endcase
	end

	afd_alu8 u_alu (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.cin(alu_cin),
		.res(alu_r),
		.co(alu_c),
		.ho(alu_h),
		.vo(alu_v)
	);

	// Products and word arithmetic, side by side with the byte ALU.
	logic msa, msb, mfrac;
	logic signed [17:0] prod;
	logic [15:0] mres, pair, wres;
	logic [16:0] wsum;

	always_comb begin
		msa = w_op inside {OP_SPROD, OP_MPROD, OP_FSPROD, OP_FMPROD};
		msb = w_op inside {OP_SPROD, OP_FSPROD};
		mfrac = w_op inside {OP_FUPROD, OP_FSPROD, OP_FMPROD};
		prod = $signed({msa & ra[7], ra}) * $signed({msb & rb[7], rb}); // RULE9
		mres = mfrac ? {prod[14:0], 1'b0} : prod[15:0]; // RULE10
		pair = {rf_q[w_dhi], ra};
		if (w_op == OP_WORD_SUM) begin
			wsum = {1'b0, pair} + {9'h000, k}; // RULE2
		end else begin
			wsum = {1'b0, pair} - {9'h000, k}; // RULE2
		end
		wres = wsum[15:0];
	end

	logic wr, fa, fl, chain;
	logic [2:0] cyc;

	always_comb begin
		rf_d = rf_q;
		stk_d = stk_q;
		sp_d = sp_q;
		flags_d = flags_q;
		pc_d = pc_q;
		imm_d = imm_q;
		st_d = st_q;
		cnt_d = cnt_q;
		cyc_d = cyc_q;
		op_d = op_q;
		dst_d = dst_q;
		src_d = src_q;
		rdata_d = rdata_q;
		wr = 1'b0;
		fa = 1'b0;
		fl = 1'b0;
		chain = 1'b0;
		cyc = CYC_ONE;
		// Requests wait while an instruction is still running.
		resp_d = (AVS_READ | AVS_WRITE) & ~resp_q & ~busy;
		if (busy) begin
			if (cnt_q == 3'h0) begin
				st_d = ST_IDLE;
			end else begin
				cnt_d = cnt_q - 3'h1;
			end
		end
		if (resp_d && AVS_READ) begin
			case (AVS_ADDRESS)
				ADDR_CMD: rdata_d = {11'h000, src_q, 3'h0, dst_q, 2'h0, op_q};
				ADDR_IMM: rdata_d = {16'h0000, imm_q};
				ADDR_FLAGS: rdata_d = {24'h00_0000, flags_q};
				ADDR_PC: rdata_d = {16'h0000, pc_q};
				ADDR_STATUS: rdata_d = {16'h0000, 8'(sp_q), 1'b0, cyc_q, 3'h0, busy};
				default: begin
					rdata_d = 32'h0000_0000;
					if (AVS_ADDRESS[7] && (AVS_ADDRESS[1:0] == 2'h0)) begin
						rdata_d = {24'h00_0000, rf_q[AVS_ADDRESS[6:2]]};
					end
				end
			endcase
		end
		if (acc && AVS_WRITE) begin
			case (AVS_ADDRESS)
				ADDR_IMM, ADDR_PC: begin
					if (AVS_ADDRESS == ADDR_IMM) begin
						if (AVS_BYTEENABLE[0]) imm_d[7:0] = AVS_WRITEDATA[7:0];
						if (AVS_BYTEENABLE[1]) imm_d[15:8] = AVS_WRITEDATA[15:8];
					end else begin
						if (AVS_BYTEENABLE[0]) pc_d[7:0] = AVS_WRITEDATA[7:0];
						if (AVS_BYTEENABLE[1]) pc_d[15:8] = AVS_WRITEDATA[15:8];
					end
				end
				ADDR_FLAGS: if (AVS_BYTEENABLE[0]) flags_d = AVS_WRITEDATA[7:0];
				default: begin
					if (AVS_ADDRESS[7] && (AVS_ADDRESS[1:0] == 2'h0) && AVS_BYTEENABLE[0]) begin
						rf_d[AVS_ADDRESS[6:2]] = AVS_WRITEDATA[7:0];
					end
				end
			endcase
		end
		if (go) begin
			pc_d = pc_q + PC_STEP;
			case (w_op)
				OP_ADD, OP_ADD_CARRY: begin
					wr = 1'b1;
					fa = 1'b1; // RULE1
				end
				OP_DIFF, OP_IMM_DIFF, OP_TWOS_INVERT: begin
					wr = 1'b1;
					fa = 1'b1; // RULE3 RULE4 RULE14
				end
				OP_DIFF_BORROW, OP_IMM_DIFF_BORROW: begin
					wr = 1'b1;
					fa = 1'b1;
					chain = 1'b1; // RULE5
				end
				OP_CMP, OP_CMP_IMM: fa = 1'b1; // RULE12
				OP_CMP_BORROW: begin
					fa = 1'b1;
					chain = 1'b1; // RULE12
				end
				OP_AND, OP_IMM_MASK, OP_OR, OP_IMM_MERGE, OP_XOR, OP_SET_BITS,
				OP_CLEAR_BITS, OP_INC, OP_DEC, OP_TEST, OP_ZERO: begin
					wr = 1'b1;
					fl = 1'b1; // RULE6 RULE7 RULE8
				end
				OP_INVERT: begin
					wr = 1'b1;
					fl = 1'b1;
					flags_d[F_C] = 1'b1; // RULE14
				end
				OP_FILL_ONES: rf_d[w_dst] = 8'hFF; // RULE14
				OP_WORD_SUM, OP_WORD_DIFF: begin
					rf_d[w_dst] = wres[7:0];
					rf_d[w_dhi] = wres[15:8];
					flags_d[F_Z] = (wres == 16'h0000);
					flags_d[F_C] = wsum[16];
					flags_d[F_N] = wres[15];
					if (w_op == OP_WORD_SUM) begin
						flags_d[F_V] = ~pair[15] & wres[15];
					end else begin
						flags_d[F_V] = pair[15] & ~wres[15];
					end
					flags_d[F_S] = flags_d[F_N] ^ flags_d[F_V];
					cyc = CYC_WORD; // RULE2
				end
				OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD, OP_FSPROD, OP_FMPROD: begin
					rf_d[REG_PROD_LO] = mres[7:0];
					rf_d[REG_PROD_HI] = mres[15:8];
					flags_d[F_C] = prod[15];
					flags_d[F_Z] = (mres == 16'h0000);
					cyc = CYC_PROD; // RULE9 RULE10
				end
				OP_SKIP_EQ: begin
					if (ra == rb) begin
						pc_d = pc_q + (w_long ? PC_SKIP_LONG : PC_SKIP_SHORT);
						cyc = w_long ? CYC_SKIP_LONG : CYC_SKIP_SHORT; // RULE11
					end
				end
				OP_REL_JUMP: begin
					pc_d = pc_q + imm_q + PC_STEP;
					cyc = CYC_JUMP_REL; // RULE13
				end
				OP_PTR_JUMP: begin
					pc_d = {rf_q[REG_Z_HI], rf_q[REG_Z_LO]};
					cyc = CYC_JUMP_REL; // RULE13
				end
				OP_ABS_JUMP: begin
					pc_d = imm_q;
					cyc = CYC_JUMP_ABS; // RULE13
				end
				OP_REL_CALL: begin
					stk_d[sp_q] = pc_q + PC_STEP;
					sp_d = sp_q + SPW'(1);
					pc_d = pc_q + imm_q + PC_STEP;
					cyc = CYC_CALL; // RULE13
				end
				OP_SUB_EXIT, OP_INT_EXIT: begin
					sp_d = sp_q - SPW'(1);
					pc_d = stk_q[sp_d];
					if (w_op == OP_INT_EXIT) flags_d[F_I] = 1'b1;
					cyc = CYC_EXIT; // RULE13
				end
				default: cyc = CYC_ONE;
			endcase
			if (wr) rf_d[w_dst] = alu_r;
			if (fa || fl) begin
				// Borrow chains keep Z low once an earlier byte was non-zero.
				flags_d[F_Z] = (alu_r == 8'h00) & (~chain | flags_q[F_Z]);
				flags_d[F_N] = alu_r[7];
				flags_d[F_V] = alu_v;
			end
			if (fa) begin
				flags_d[F_C] = alu_c;
				flags_d[F_H] = alu_h;
			end
			op_d = w_op;
			dst_d = w_dst;
			src_d = w_src;
			cyc_d = cyc;
			cnt_d = cyc - 3'h1;
			st_d = ST_EXEC;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int i = 0; i < 32; i++) begin
				rf_q[i] <= REG_RST;
			end
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stk_q[i] <= PC_RST;
			end
			sp_q <= '0;
			flags_q <= FLAGS_RST;
			pc_q <= PC_RST;
			imm_q <= IMM_RST;
			st_q <= ST_IDLE;
			cnt_q <= 3'h0;
			cyc_q <= 3'h0;
			op_q <= OP_ADD;
			dst_q <= 5'h00;
			src_q <= 5'h00;
			resp_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			rf_q <= rf_d;
			stk_q <= stk_d;
			sp_q <= sp_d;
			flags_q <= flags_d;
			pc_q <= pc_d;
			imm_q <= imm_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			cyc_q <= cyc_d;
			op_q <= op_d;
			dst_q <= dst_d;
			src_q <= src_d;
			resp_q <= resp_d;
			rdata_q <= rdata_d;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	property p_add;
		go && w_op == OP_ADD |=> rf_q[dst_q] == 8'($past(ra) + $past(rb)) && busy ##1 !busy;
	endproperty
	a_add: assert property (p_add) else $error("add result or timing wrong"); // RULE1
	property p_word;
		go && w_op == OP_WORD_SUM |=> busy[*2] ##1 !busy && flags_q[F_S] == (flags_q[F_N] ^ flags_q[F_V]);
	endproperty
	a_word: assert property (p_word) else $error("word sum timing or sign wrong"); // RULE2
	property p_diff;
		go && w_op == OP_DIFF |=> rf_q[dst_q] == 8'($past(ra) - $past(rb));
	endproperty
	a_diff: assert property (p_diff) else $error("difference wrong"); // RULE3
	property p_imm_diff;
		go && w_op == OP_IMM_DIFF |=> rf_q[dst_q] == 8'($past(ra) - $past(k)) && busy ##1 !busy;
	endproperty
	a_imm_diff: assert property (p_imm_diff) else $error("immediate difference wrong"); // RULE4
	property p_imm_borrow;
		go && w_op == OP_IMM_DIFF_BORROW |=> rf_q[dst_q] == 8'($past(ra) - $past(k) - $past(cf));
	endproperty
	a_imm_borrow: assert property (p_imm_borrow) else $error("borrow not subtracted"); // RULE5
	property p_logic;
		go && w_op inside {OP_AND, OP_OR, OP_XOR} |=> !flags_q[F_V] && flags_q[F_C] == $past(cf);
	endproperty
	a_logic: assert property (p_logic) else $error("logic op touched wrong flags"); // RULE6
	property p_clear;
		go && w_op == OP_CLEAR_BITS |=> rf_q[dst_q] == ($past(ra) & ~$past(k));
	endproperty
	a_clear: assert property (p_clear) else $error("clear bits wrong"); // RULE7
	property p_test;
		go && w_op == OP_TEST |=> flags_q[F_Z] == ($past(ra) == 8'h00) && flags_q[F_N] == $past(ra[7]);
	endproperty
	a_test: assert property (p_test) else $error("zero-or-minus flags wrong"); // RULE8
	property p_uprod;
		go && w_op == OP_UPROD |=> {rf_q[REG_PROD_HI], rf_q[REG_PROD_LO]}
			== {8'h00, $past(ra)} * {8'h00, $past(rb)} && busy[*2] ##1 !busy;
	endproperty
	a_uprod: assert property (p_uprod) else $error("unsigned product wrong"); // RULE9
	property p_fprod;
		go && w_op == OP_FUPROD |=> {rf_q[REG_PROD_HI], rf_q[REG_PROD_LO]}
			== (({8'h00, $past(ra)} * {8'h00, $past(rb)}) << 1);
	endproperty
	a_fprod: assert property (p_fprod) else $error("fractional product wrong"); // RULE10
	property p_skip;
		go && w_op == OP_SKIP_EQ && ra == rb && !w_long |=> pc_q == $past(pc_q) + PC_SKIP_SHORT
			&& busy ##1 busy ##1 !busy;
	endproperty
	a_skip: assert property (p_skip) else $error("short skip wrong"); // RULE11
	property p_cmp;
		go && w_op == OP_CMP |=> rf_q[dst_q] == $past(ra) && flags_q[F_Z] == ($past(ra) == $past(rb));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare stored or misflagged"); // RULE12
	property p_exit;
		go && w_op == OP_SUB_EXIT |=> busy[*4] ##1 !busy;
	endproperty
	a_exit: assert property (p_exit) else $error("exit timing wrong"); // RULE13
	property p_fill;
		go && w_op == OP_FILL_ONES |=> rf_q[dst_q] == 8'hFF && flags_q == $past(flags_q);
	endproperty
	a_fill: assert property (p_fill) else $error("fill ones wrong"); // RULE14
endmodule : afd_core

// File: tb/alu_and_flow_datapath_bench.sv
`timescale 1ns/1ps
module alu_and_flow_datapath_bench;
	import afd_pkg::*;

	typedef struct packed {
		afd_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] fi;
		logic [15:0] r;
		logic [7:0] fo;
		logic [2:0] cyc;
	} afd_row_t;

	// Operand a sits in register 16, b in register 17 and in the constant.
	// Word results are checked on the low half only; products land in registers 1:0.
	localparam afd_row_t ROWS [31] = '{
		'{OP_CMP, 8'h05, 8'h05, 8'h00, 16'h0005, 8'h02, 3'h1},
		'{OP_CMP_BORROW, 8'h05, 8'h04, 8'h01, 16'h0005, 8'h00, 3'h1},
		'{OP_ADD, 8'h0F, 8'h01, 8'h00, 16'h0010, 8'h20, 3'h1},
		'{OP_ADD_CARRY, 8'hFF, 8'h00, 8'h01, 16'h0000, 8'h23, 3'h1},
		'{OP_WORD_SUM, 8'hFF, 8'hFF, 8'h00, 16'h00FE, 8'h01, 3'h2},
		'{OP_WORD_DIFF, 8'h00, 8'h01, 8'h3F, 16'h00FF, 8'h20, 3'h2},
		'{OP_DIFF, 8'h10, 8'h01, 8'h00, 16'h000F, 8'h20, 3'h1},
		'{OP_IMM_DIFF, 8'h80, 8'h01, 8'h00, 16'h007F, 8'h28, 3'h1},
		'{OP_DIFF_BORROW, 8'h00, 8'h00, 8'h01, 16'h00FF, 8'h25, 3'h1},
		'{OP_IMM_DIFF_BORROW, 8'h05, 8'h04, 8'h03, 16'h0000, 8'h02, 3'h1},
		'{OP_AND, 8'hF0, 8'h0F, 8'h3F, 16'h0000, 8'h33, 3'h1},
		'{OP_IMM_MASK, 8'hF0, 8'hFF, 8'h00, 16'h00F0, 8'h04, 3'h1},
		'{OP_OR, 8'h80, 8'h01, 8'h3F, 16'h0081, 8'h35, 3'h1},
		'{OP_IMM_MERGE, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h02, 3'h1},
		'{OP_XOR, 8'hAA, 8'h55, 8'h00, 16'h00FF, 8'h04, 3'h1},
		'{OP_INVERT, 8'h00, 8'h00, 8'h00, 16'h00FF, 8'h05, 3'h1},
		'{OP_TWOS_INVERT, 8'h01, 8'h00, 8'h00, 16'h00FF, 8'h25, 3'h1},
		'{OP_SET_BITS, 8'h01, 8'h80, 8'h00, 16'h0081, 8'h04, 3'h1},
		'{OP_CLEAR_BITS, 8'hFF, 8'h0F, 8'h00, 16'h00F0, 8'h04, 3'h1},
		'{OP_INC, 8'h7F, 8'h00, 8'h00, 16'h0080, 8'h0C, 3'h1},
		'{OP_DEC, 8'h00, 8'h00, 8'h01, 16'h00FF, 8'h05, 3'h1},
		'{OP_TEST, 8'h00, 8'h00, 8'h0C, 16'h0000, 8'h02, 3'h1},
		'{OP_ZERO, 8'hAA, 8'h00, 8'h00, 16'h0000, 8'h02, 3'h1},
		'{OP_FILL_ONES, 8'h00, 8'h00, 8'h3F, 16'h00FF, 8'h3F, 3'h1},
		'{OP_UPROD, 8'hFF, 8'hFF, 8'h00, 16'hFE01, 8'h01, 3'h2},
		'{OP_SPROD, 8'hFF, 8'hFF, 8'h00, 16'h0001, 8'h00, 3'h2},
		'{OP_MPROD, 8'h80, 8'h02, 8'h00, 16'hFF00, 8'h01, 3'h2},
		'{OP_FUPROD, 8'h80, 8'h80, 8'h00, 16'h8000, 8'h00, 3'h2},
		'{OP_FSPROD, 8'h80, 8'h80, 8'h00, 16'h8000, 8'h00, 3'h2},
		'{OP_FMPROD, 8'h00, 8'h55, 8'h3C, 16'h0000, 8'h3E, 3'h2},
		'{OP_CMP_IMM, 8'h01, 8'h02, 8'h00, 16'h0001, 8'h25, 3'h1}
	};

	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic EXEC_BUSY;
	logic [15:0] PROG_COUNTER;
	logic [31:0] q;
	int n_errors = 0;
	int num_checks = 0;

	afd_core #(.STACK_DEPTH(8)) uut (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST),
		.EXEC_BUSY(EXEC_BUSY),
		.PROG_COUNTER(PROG_COUNTER)
	);

	always #25 MCLK = ~MCLK;

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		num_checks++;
		if (seen !== expv) begin
			n_errors++;
			$display("ERROR at %0t ns: saw %h, expected %h", $time, seen, expv);
		end
	endtask : check

	// Waitrequest and read data are read just after the rising edge, before the design's
	// flops update, so they hold the values that this edge samples.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int k;
		k = 0;
		@(posedge MCLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= d;
		do begin
			@(posedge MCLK);
			k++;
		end while (AVS_WAITREQUEST !== 1'b0 && k < 40);
		check({31'h0000_0000, AVS_WAITREQUEST}, 32'h0000_0000);
		r = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus(1'b1, a, d, unused);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0000_0000, r);
	endtask : rd

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		rd(a, r);
		check(r, e);
	endtask : chk

	function automatic logic [7:0] ra(input int n);
		return ADDR_RF_BASE + 8'(4 * n);
	endfunction : ra

	function automatic logic [31:0] cmd(input afd_op_t op, input logic lng);
		return {7'h00, lng, 3'h0, 5'h11, 3'h0, 5'h10, 2'h0, op};
	endfunction : cmd

	// Reading the status word stalls until the instruction retires, so the
	// cycle count and the program counter are settled when they are compared.
	task automatic run_op(input afd_op_t op, input logic lng, input logic [15:0] epc,
			input logic [2:0] cyc);
		wr(ADDR_CMD, cmd(op, lng));
		rd(ADDR_STATUS, q);
		check({29'h0000_0000, q[6:4]}, {29'h0000_0000, cyc});
		check({16'h0000, PROG_COUNTER}, {16'h0000, epc});
	endtask : run_op

	task automatic complete_run;
		$display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge MCLK);
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		check({15'h0000, EXEC_BUSY, PROG_COUNTER}, 32'h0000_0000);
		chk(ADDR_FLAGS, 32'h0000_0000);
		chk(ADDR_PC, 32'h0000_0000);
		chk(ADDR_IMM, 32'h0000_0000);
		chk(ra(5), 32'h0000_0000);
		wr(8'h14, 32'hFFFF_FFFF);
		chk(8'h14, 32'h0000_0000);
		wr(ADDR_STATUS, 32'hFFFF_FFFF);
		chk(ADDR_STATUS, 32'h0000_0000);
		foreach (ROWS[i]) begin
			wr(ra(16), {24'h00_0000, ROWS[i].a});
			wr(ra(17), {24'h00_0000, ROWS[i].b});
			wr(ADDR_IMM, {24'h00_0000, ROWS[i].b});
			wr(ADDR_FLAGS, {24'h00_0000, ROWS[i].fi});
			rd(ADDR_PC, q);
			run_op(ROWS[i].op, 1'b0, q[15:0] + PC_STEP, ROWS[i].cyc);
			chk(ADDR_FLAGS, {24'h00_0000, ROWS[i].fo});
			if (ROWS[i].op inside {[OP_UPROD:OP_FMPROD]}) begin
				chk(ra(1), {24'h00_0000, ROWS[i].r[15:8]});
				chk(ra(0), {24'h00_0000, ROWS[i].r[7:0]});
				chk(ra(16), {24'h00_0000, ROWS[i].a});
			end else begin
				chk(ra(16), {24'h00_0000, ROWS[i].r[7:0]});
			end
		end
		// Equal and unequal operands, with short and long following instructions.
		wr(ra(16), 32'h0000_0005);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_PC, 32'h0000_0010);
			wr(ra(17), (i == 0) ? 32'h0000_0006 : 32'h0000_0005);
			run_op(OP_SKIP_EQ, 1'(i == 2), 16'h0010 + 16'(i + 1), 3'(i + 1));
		end
		wr(ADDR_PC, 32'h0000_0020);
		wr(ADDR_IMM, 32'h0000_FFFE);
		run_op(OP_REL_JUMP, 1'b0, 16'h001F, 3'h2);
		wr(ADDR_IMM, 32'h0000_1234);
		run_op(OP_ABS_JUMP, 1'b0, 16'h1234, 3'h3);
		wr(ra(30), 32'h0000_0056);
		wr(ra(31), 32'h0000_0004);
		run_op(OP_PTR_JUMP, 1'b0, 16'h0456, 3'h2);
		wr(ADDR_PC, 32'h0000_0100);
		wr(ADDR_IMM, 32'h0000_0010);
		run_op(OP_REL_CALL, 1'b0, 16'h0111, 3'h3);
		check({24'h00_0000, q[15:8]}, 32'h0000_0001);
		run_op(OP_SUB_EXIT, 1'b0, 16'h0101, 3'h4);
		check({24'h00_0000, q[15:8]}, 32'h0000_0000);
		wr(ADDR_FLAGS, 32'h0000_0000);
		run_op(OP_REL_CALL, 1'b0, 16'h0112, 3'h3);
		run_op(OP_INT_EXIT, 1'b0, 16'h0102, 3'h4);
		chk(ADDR_FLAGS, 32'h0000_0080);
		chk(ADDR_CMD, cmd(OP_INT_EXIT, 1'b0));
		complete_run();
	end
endmodule : alu_and_flow_datapath_bench
